// [verilog/btc_defs.svh]
// Constants for the branch target and condition unit: register offsets,
// instruction field positions, opcodes and reset values.
// Assumes 32-bit instruction words, with bit 0 as the least significant bit.
`ifndef BTC_DEFS_SVH
`define BTC_DEFS_SVH

// Register word indexes on the Avalon-MM slave. Byte address = 4 * index.
`define BTC_OFF_LINK_LO 3'h0
`define BTC_OFF_LINK_HI 3'h1
`define BTC_OFF_COUNT_LO 3'h2
`define BTC_OFF_COUNT_HI 3'h3
`define BTC_OFF_COND 3'h4
`define BTC_OFF_STATUS 3'h5
`define BTC_OFF_CTRL 3'h6

// Control register: bit 0 selects 64-bit addressing mode.
`define BTC_CTRL_MODE64_BIT 0
`define BTC_CTRL_RESET 32'h0000_0001

// Status register bit positions.
`define BTC_STAT_TAKEN_BIT 0
`define BTC_STAT_PREDICT_BIT 1
`define BTC_STAT_INVALID_BIT 2
`define BTC_STAT_MODE64_BIT 3

// Reset values of the architected registers.
`define BTC_LINK_RESET 64'h0000_0000_0000_0000
`define BTC_COUNT_RESET 64'h0000_0000_0000_0000
`define BTC_COND_RESET 32'h0000_0000

// Instruction fields, little-endian bit positions.
`define BTC_LINK_FLAG_BIT 0
`define BTC_ABS_FLAG_BIT 1
`define BTC_SIGN_BIT 15
`define BTC_OPC_MSB 31
`define BTC_OPC_LSB 26
`define BTC_OPTS_MSB 25
`define BTC_OPTS_LSB 21
`define BTC_SEL_MSB 20
`define BTC_SEL_LSB 16
`define BTC_XO_MSB 10
`define BTC_XO_LSB 1
`define BTC_LDISP_MSB 25
`define BTC_LDISP_LSB 2
`define BTC_CDISP_MSB 15
`define BTC_CDISP_LSB 2

// Primary opcodes and extended opcodes of the branch forms.
`define BTC_OPC_LONG 6'h12
`define BTC_OPC_COND 6'h10
`define BTC_OPC_XL 6'h13
`define BTC_XO_VIA_LINK 10'h010
`define BTC_XO_VIA_COUNT 10'h210

// Width of one instruction step in bytes.
`define BTC_INSTR_BYTES 64'h0000_0000_0000_0004

`endif

// [verilog/btc_pkg.sv]
// Types shared by the branch target and condition unit.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package btc_pkg;

    // Which branch form the presented instruction word carries.
    typedef enum logic [2:0]
    {
        BK_NONE,
        BK_LONG,
        BK_COND,
        BK_VIA_LINK,
        BK_VIA_COUNT
    } btc_kind_type;

endpackage : btc_pkg

`default_nettype wire

// [verilog/btc_branch_unit.sv]
// Branch target and condition unit: resolves one branch word per request,
// updates the link and count registers and reports the next fetch address.
// Assumes the fetch path presents a word with its address on the core clock,
// and software reaches link, count and condition words over Avalon-MM.
//
// Overview of operation
// - Taken relative conditional: address plus scaled displacement.
// - Absolute flag selects absolute or relative target.
// - Unconditional absolute: scaled long displacement only.
// - Taken absolute conditional: scaled conditional displacement.
// - Link flag writes next address into link.
// - Via-link target is link with low bits cleared.
// - Via-count target is count with low bits cleared.
// - Via forms update link even when not taken.
// - Count zero test covers low half in 32-bit mode.
// - Decrement always acts on full 64-bit count.
// - Decrement codes combine count test and condition bit.
// - Condition-only codes leave count untouched.
// - Count-only codes decrement and ignore condition bit.
// - Branch-always code never decrements, has no hint.
// - Five-bit selector picks one of 32 condition bits.
// - Clear hint: negative displacement predicts taken; hint inverts.
// - Displacement sign drives prediction for absolute targets too.
// - Prediction formula from option bits, sign and hint.
// - 32-bit mode clears upper target half last.
// - Unconditional relative: address plus scaled long displacement.
// - Via-count with decrement requested is an invalid form.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`include "btc_defs.svh"
`default_nettype none

module btc_branch_unit
    import btc_pkg::*;
(
    input wire logic i_core_clk,               // Core clock, 100 MHz.
    input wire logic i_nrst,                   // Asynchronous reset, low.
    input wire logic i_branch_valid,           // Branch word presented.
    input wire logic [31:0] i_instr,           // Branch instruction word.
    input wire logic [63:0] i_cia,             // Current instruction address.
    output logic o_resolve_valid,              // Result pulse, one cycle.
    output logic [63:0] o_next_addr,           // Next fetch address.
    output logic o_taken,                      // Branch resolved taken.
    output logic o_predict_taken,              // Static prediction.
    output logic o_invalid_form,               // Invalid form seen.
    output logic [63:0] o_link_reg,            // Current link register.
    output logic [63:0] o_count_reg,           // Current count register.
    input wire logic [2:0] i_avs_address,      // Word index.
    input wire logic i_avs_read,               // Read strobe.
    input wire logic i_avs_write,              // Write strobe.
    input wire logic [31:0] i_avs_writedata,   // Write data.
    input wire logic [3:0] i_avs_byteenable,   // Write byte lanes.
    output logic [31:0] o_avs_readdata,        // Read data.
    output logic o_avs_waitrequest             // Stall while busy.
);

    logic rst_meta;
    logic rst_sync_n;
    logic [63:0] link_reg;
    logic [63:0] count_reg;
    logic [31:0] cond_reg;
    logic [31:0] ctrl_reg;
    logic last_taken;
    logic last_predict;
    logic last_invalid;
    logic avs_ack;
    logic bus_wr;
    logic mode64;
    btc_kind_type kind;
    logic [5:0] opcode;
    logic [9:0] ext_opcode;
    logic [4:0] opts;
    logic [4:0] cond_sel;
    logic cond_bit;
    logic [63:0] long_disp;
    logic [63:0] cond_disp;
    logic [63:0] seq_addr;
    logic [63:0] dec_count;
    logic count_nonzero;
    logic cond_ok;
    logic count_ok;
    logic always_code;
    logic cond_predict;
    logic next_taken;
    logic next_predict;
    logic next_invalid;
    logic next_dec;
    logic next_link_wr;
    logic [63:0] next_target;
    logic [63:0] next_addr;

    // Merges a bus write into one 32-bit word under its byte lanes.
    function automatic logic [31:0] merge_word(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] lanes);
        logic [31:0] result;
        result = old_word;
        for (int lane = 0; lane < 4; lane++)
        begin
            if (lanes[lane])
            begin
                result[lane*8 +: 8] = new_word[lane*8 +: 8];
            end
        end
        return result;
    endfunction

    // Clears the upper half of an address when running in 32-bit mode.
    function automatic logic [63:0] mode_addr(input logic [63:0] addr,
                                              input logic wide);
        return wide ? addr : {32'h0000_0000, addr[31:0]};
    endfunction

    // Release the reset through two flip-flops; assertion stays asynchronous.
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Field extraction; bit 0 is the least significant instruction bit.
    assign opcode = i_instr[`BTC_OPC_MSB:`BTC_OPC_LSB];
    assign ext_opcode = i_instr[`BTC_XO_MSB:`BTC_XO_LSB];
    assign opts = i_instr[`BTC_OPTS_MSB:`BTC_OPTS_LSB];
    assign cond_sel = i_instr[`BTC_SEL_MSB:`BTC_SEL_LSB];
    assign mode64 = ctrl_reg[`BTC_CTRL_MODE64_BIT];

    // Condition bit 0 is the most significant bit of the condition word.
    assign cond_bit = cond_reg[5'd31 - cond_sel];

    // Displacements are sign-extended and scaled to a word address.
    assign long_disp = {{38{i_instr[`BTC_LDISP_MSB]}},
                        i_instr[`BTC_LDISP_MSB:`BTC_LDISP_LSB], 2'b00};
    assign cond_disp = {{48{i_instr[`BTC_CDISP_MSB]}},
                        i_instr[`BTC_CDISP_MSB:`BTC_CDISP_LSB], 2'b00};
    assign seq_addr = i_cia + `BTC_INSTR_BYTES;

    // The whole 64-bit count is decremented; only the test width varies.
    assign dec_count = count_reg - 64'h0000_0000_0000_0001;
    assign count_nonzero = mode64 ? (dec_count != 64'h0)
                                  : (dec_count[31:0] != 32'h0);

    // Decode the branch form from the primary and extended opcodes.
    always_comb
    begin
        kind = BK_NONE;
        if (opcode == `BTC_OPC_LONG)
            kind = BK_LONG;
        else if (opcode == `BTC_OPC_COND)
            kind = BK_COND;
        else if (opcode == `BTC_OPC_XL && ext_opcode == `BTC_XO_VIA_LINK)
            kind = BK_VIA_LINK;
        else if (opcode == `BTC_OPC_XL && ext_opcode == `BTC_XO_VIA_COUNT)
            kind = BK_VIA_COUNT;
    end

    // Option bits, in field order opts[4] down to opts[0]:
    // opts[4] ignores the condition, opts[3] is the wanted sense,
    // opts[2] suppresses the decrement, opts[1] branches on zero and
    // opts[0] is the hint. Bits that a code marks don't-care never steer
    // anything, because each term is masked by the bit that disables it.
    assign cond_ok = opts[4] | (cond_bit == opts[3]);
    assign count_ok = opts[2] | (count_nonzero ^ opts[1]);

    // Static prediction follows the sign, or is set for branch-always; the
    // hint flips it, except for branch-always codes, which carry no hint.
    assign always_code = opts[4] & opts[2];
    assign cond_predict = (always_code | i_instr[`BTC_SIGN_BIT])
                          ^ (opts[0] & ~always_code);

    // Resolve direction, target, prediction and side effects.
    always_comb
    begin
        next_taken = 1'b0;
        next_predict = 1'b0;
        next_invalid = 1'b0;
        next_dec = 1'b0;
        next_link_wr = 1'b0;
        next_target = seq_addr;
        unique case (kind)
            BK_LONG:
            begin
                next_taken = 1'b1;
                next_predict = 1'b1;
                next_target = i_instr[`BTC_ABS_FLAG_BIT] ? long_disp
                              : i_cia + long_disp;
                next_link_wr = i_instr[`BTC_LINK_FLAG_BIT];
            end
            BK_COND:
            begin
                next_taken = cond_ok & count_ok;
                next_dec = ~opts[2];
                // Sign of the displacement drives prediction either way.
                next_predict = cond_predict;
                next_target = i_instr[`BTC_ABS_FLAG_BIT] ? cond_disp
                              : i_cia + cond_disp;
                next_link_wr = i_instr[`BTC_LINK_FLAG_BIT];
            end
            BK_VIA_LINK:
            begin
                next_taken = cond_ok & count_ok;
                next_dec = ~opts[2];
                next_predict = cond_predict;
                next_target = {link_reg[63:2], 2'b00};
                next_link_wr = i_instr[`BTC_LINK_FLAG_BIT];
            end
            BK_VIA_COUNT:
            begin
                // A decrementing count form is refused with no side effect.
                if (!opts[2])
                begin
                    next_invalid = 1'b1;
                end
                else
                begin
                    next_taken = cond_ok;
                    next_predict = cond_predict;
                    next_target = {count_reg[63:2], 2'b00};
                    next_link_wr = i_instr[`BTC_LINK_FLAG_BIT];
                end
            end
            BK_NONE: next_invalid = 1'b0;
        endcase
        next_addr = mode_addr(next_taken ? next_target : seq_addr,
                              mode64);
    end

    // A bus write lands on the edge where waitrequest is low.
    assign bus_wr = i_avs_write & avs_ack;

    // Link register: a branch update beats a bus write in the same cycle.
    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            link_reg <= `BTC_LINK_RESET;
        end
        else if (i_branch_valid && next_link_wr)
        begin
            link_reg <= mode_addr(seq_addr, mode64);
        end
        else if (bus_wr && i_avs_address == `BTC_OFF_LINK_LO)
        begin
            link_reg[31:0] <= merge_word(link_reg[31:0], i_avs_writedata,
                                         i_avs_byteenable);
        end
        else if (bus_wr && i_avs_address == `BTC_OFF_LINK_HI)
        begin
            link_reg[63:32] <= merge_word(link_reg[63:32], i_avs_writedata,
                                          i_avs_byteenable);
        end
    end

    // Count register: decrement commits whether or not the branch is taken.
    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            count_reg <= `BTC_COUNT_RESET;
        end
        else if (i_branch_valid && next_dec)
        begin
            count_reg <= dec_count;
        end
        else if (bus_wr && i_avs_address == `BTC_OFF_COUNT_LO)
        begin
            count_reg[31:0] <= merge_word(count_reg[31:0], i_avs_writedata,
                                          i_avs_byteenable);
        end
        else if (bus_wr && i_avs_address == `BTC_OFF_COUNT_HI)
        begin
            count_reg[63:32] <= merge_word(count_reg[63:32], i_avs_writedata,
                                           i_avs_byteenable);
        end
    end

    // Condition and control words are written by software only.
    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            cond_reg <= `BTC_COND_RESET;
            ctrl_reg <= `BTC_CTRL_RESET;
        end
        else if (bus_wr && i_avs_address == `BTC_OFF_COND)
        begin
            cond_reg <= merge_word(cond_reg, i_avs_writedata,
                                   i_avs_byteenable);
        end
        else if (bus_wr && i_avs_address == `BTC_OFF_CTRL)
        begin
            ctrl_reg <= merge_word(ctrl_reg, i_avs_writedata,
                                   i_avs_byteenable);
        end
    end

    // Resolution results are registered; the valid and invalid flags pulse for one cycle, the others hold until the next result.
    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            o_resolve_valid <= 1'b0;
            o_next_addr <= 64'h0000_0000_0000_0000;
            o_taken <= 1'b0;
            o_predict_taken <= 1'b0;
            o_invalid_form <= 1'b0;
        end
        else
        begin
            o_resolve_valid <= i_branch_valid && kind != BK_NONE;
            o_invalid_form <= i_branch_valid && next_invalid;
            if (i_branch_valid && kind != BK_NONE)
            begin
                o_next_addr <= next_addr;
                o_taken <= next_taken;
                o_predict_taken <= next_predict;
            end
        end
    end

    // Status of the last resolved branch, kept for software to read.
    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            last_taken <= 1'b0;
            last_predict <= 1'b0;
            last_invalid <= 1'b0;
        end
        else if (i_branch_valid && kind != BK_NONE)
        begin
            last_taken <= next_taken;
            last_predict <= next_predict;
            last_invalid <= next_invalid;
        end
    end

    // Every access waits exactly one cycle; this keeps the read mux off
    // the same path as the decode of the address.
    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            avs_ack <= 1'b0;
        end
        else
        begin
            avs_ack <= (i_avs_read | i_avs_write) & ~avs_ack;
        end
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~avs_ack;

    // Read data is latched when the request arrives; unmapped reads give 0.
    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            o_avs_readdata <= 32'h0000_0000;
        end
        else if (i_avs_read && !avs_ack)
        begin
            unique case (i_avs_address)
                `BTC_OFF_LINK_LO: o_avs_readdata <= link_reg[31:0];
                `BTC_OFF_LINK_HI: o_avs_readdata <= link_reg[63:32];
                `BTC_OFF_COUNT_LO: o_avs_readdata <= count_reg[31:0];
                `BTC_OFF_COUNT_HI: o_avs_readdata <= count_reg[63:32];
                `BTC_OFF_COND: o_avs_readdata <= cond_reg;
                `BTC_OFF_STATUS:
                begin
                    o_avs_readdata <= 32'h0000_0000;
                    o_avs_readdata[`BTC_STAT_TAKEN_BIT] <= last_taken;
                    o_avs_readdata[`BTC_STAT_PREDICT_BIT] <= last_predict;
                    o_avs_readdata[`BTC_STAT_INVALID_BIT] <= last_invalid;
                    o_avs_readdata[`BTC_STAT_MODE64_BIT] <= mode64;
                end
                `BTC_OFF_CTRL: o_avs_readdata <= ctrl_reg;
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    assign o_link_reg = link_reg;
    assign o_count_reg = count_reg;

endmodule // btc_branch_unit

`default_nettype wire

// [test/btc_branch_unit_properties.sv]
// Port checker for the branch unit: results tied to the presented word.
// Assumes the bench keeps bus writes away from branch cycles.
`include "btc_defs.svh"
`default_nettype none
module btc_branch_unit_properties (
    input wire logic i_core_clk, // Clock.
    input wire logic i_nrst, // Reset, low.
    input wire logic i_branch_valid, // Word valid.
    input wire logic [31:0] i_instr, // Word.
    input wire logic [63:0] i_cia, // Address.
    input wire logic o_resolve_valid, // Result pulse.
    input wire logic [63:0] o_next_addr, // Next address.
    input wire logic o_taken, // Taken.
    input wire logic o_predict_taken, // Prediction.
    input wire logic o_invalid_form, // Invalid form.
    input wire logic [63:0] o_link_reg, // Link.
    input wire logic [63:0] o_count_reg, // Count.
    input wire logic i_avs_read, // Read.
    input wire logic i_avs_write, // Write.
    input wire logic o_avs_waitrequest // Stall.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Decoded word and low-half targets; the mode is not visible here.
    wire logic [5:0] opc = i_instr[31:26];
    wire logic lb = i_branch_valid && opc == `BTC_OPC_LONG;
    wire logic cb = i_branch_valid && opc == `BTC_OPC_COND;
    wire logic vc = i_branch_valid && opc == `BTC_OPC_XL
        && i_instr[10:1] == `BTC_XO_VIA_COUNT;
    wire logic [31:0] abs_t = {{6{i_instr[25]}}, i_instr[25:2], 2'b00};
    wire logic [31:0] rel_t = abs_t + i_cia[31:0];
    wire logic [31:0] seq_t = i_cia[31:0] + 32'h4;
    wire logic ba = i_instr[25] & i_instr[23];
    wire logic pr = (ba | i_instr[15]) ^ (i_instr[21] & !ba);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    property p_long_abs;
        lb && i_instr[1] |=> o_resolve_valid && o_taken
            && o_next_addr[31:0] == $past(abs_t);
    endproperty
    a_long_abs: assert property (p_long_abs) else $error("abs");
    property p_long_rel;
        lb && !i_instr[1] |=> o_next_addr[31:0] == $past(rel_t);
    endproperty
    a_long_rel: assert property (p_long_rel) else $error("rel");
    property p_link;
        (lb || cb) && i_instr[0] |=> o_link_reg[31:0] == $past(seq_t);
    endproperty
    a_link: assert property (p_link) else $error("link update");
    property p_inval;
        vc && !i_instr[23] |=> o_invalid_form && o_resolve_valid && !o_taken;
    endproperty
    a_inval: assert property (p_inval) else $error("invalid form");
    property p_seq;
        o_resolve_valid && !o_taken |-> o_next_addr[31:0] == $past(seq_t);
    endproperty
    a_seq: assert property (p_seq) else $error("sequential");
    property p_pred;
        cb |=> o_predict_taken == $past(pr);
    endproperty
    a_pred: assert property (p_pred) else $error("prediction");
    property p_dec;
        cb && !i_instr[23] |=> o_count_reg == $past(o_count_reg) - 64'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement");
    property p_keep;
        cb && i_instr[23] |=> $stable(o_count_reg);
    endproperty
    a_keep: assert property (p_keep) else $error("count kept");
    property p_wait;
        $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest
            ##1 !o_avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait shape");
    c_inval: cover property (vc && !i_instr[23]);
    c_dec: cover property (cb && !i_instr[23] ##1 o_taken);
    c_long: cover property (lb);
endmodule // btc_branch_unit_properties
bind btc_branch_unit btc_branch_unit_properties CHK (.i_core_clk, .i_nrst,
    .i_branch_valid, .i_instr, .i_cia, .o_resolve_valid, .o_next_addr,
    .o_taken, .o_predict_taken, .o_invalid_form, .o_link_reg, .o_count_reg,
    .i_avs_read, .i_avs_write, .o_avs_waitrequest);
`default_nettype wire

// [test/btc_fetch_model.sv]
// Fetch-side model: presents one branch word with its address per call.
// Assumes the caller waits for the result before the next call.
`include "btc_defs.svh"
`default_nettype none
module btc_fetch_model (
    input wire logic i_core_clk, // Core clock.
    output logic o_branch_valid, // Word presented.
    output logic [31:0] o_instr, // Branch word.
    output logic [63:0] o_cia // Word address.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_branch_valid = 1'b0;
        o_instr = 32'h0;
        o_cia = 64'h0;
    end
    // One edge of valid, then the idle lines are scrambled so that a
    // stale word can never pass for a held one.
    task automatic present(input logic [31:0] i, input logic [63:0] c);
        logic [31:0] w;
        w = i;
        if (i[31:26] == `BTC_OPC_XL)
            w[15:11] = 5'h0;
        @(posedge i_core_clk);
        o_branch_valid <= 1'b1;
        o_instr <= w;
        o_cia <= c;
        @(posedge i_core_clk);
        o_branch_valid <= 1'b0;
        o_instr <= ~w;
        o_cia <= ~c;
    endtask
endmodule // btc_fetch_model
`default_nettype wire

// [test/btc_branch_unit_tb.sv]
// Self-checking bench: register resets, then random branches of all forms.
// Assumes the fetch model drives the branch port and the checker is bound.
`include "btc_defs.svh"
`default_nettype none
module btc_branch_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [2:0] adr = 3'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    wire logic bv, rv, tk, pt, inv, wrq;
    wire logic [31:0] ins, rdat;
    wire logic [63:0] cia, nxt, lnk, cnt;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 5574;
    logic [63:0] s_lnk, s_cnt, c;
    logic [31:0] s_cond, r, x, iw;
    logic s_m64;
    btc_fetch_model FETCH (.i_core_clk(i_core_clk), .o_branch_valid(bv),
        .o_instr(ins), .o_cia(cia));
    btc_branch_unit DUT (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_branch_valid(bv), .i_instr(ins), .i_cia(cia),
        .o_resolve_valid(rv), .o_next_addr(nxt), .o_taken(tk),
        .o_predict_taken(pt), .o_invalid_form(inv), .o_link_reg(lnk),
        .o_count_reg(cnt), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wrq));
    // Free-running core clock.
    always #5 i_core_clk = ~i_core_clk;
    task automatic chk(input logic [63:0] g, input logic [63:0] e,
                       input string s);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, s);
        end
    endtask
    // Request held until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        @(posedge i_core_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= b;
        @(posedge i_core_clk);
        while (wrq !== 1'b0)
            @(posedge i_core_clk);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // The two halves are written low first; nothing else runs meanwhile.
    task automatic wr64(input logic [2:0] a, input logic [63:0] v);
        bus(1'b1, a, v[31:0], 4'hF);
        bus(1'b1, a + 3'h1, v[63:32], 4'hF);
    endtask
    // Works out the result from the shadow registers, then compares.
    task automatic run_branch(input logic [31:0] i, input logic [63:0] a);
        logic [5:0] op;
        logic ba, cb, vc, zr, lng, e_tk, e_pt, e_inv;
        logic [63:0] dn, tg, e_adr;
        op = i[31:26];
        lng = op == `BTC_OPC_LONG;
        vc = op == `BTC_OPC_XL && i[10:1] == `BTC_XO_VIA_COUNT;
        e_inv = vc && !i[23];
        dn = s_cnt - {63'h0, !i[23]};
        zr = s_m64 ? dn == 64'h0 : dn[31:0] == 32'h0;
        cb = s_cond[31 - i[20:16]];
        ba = i[25] & i[23];
        e_tk = lng || (!e_inv && (i[23] || zr == i[22])
            && (i[25] || cb == i[24]));
        e_pt = !e_inv && ((ba | i[15]) ^ (i[21] & !ba));
        if (lng)
            tg = {{38{i[25]}}, i[25:2], 2'b00} + (i[1] ? 64'h0 : a);
        else if (op == `BTC_OPC_COND)
            tg = {{48{i[15]}}, i[15:2], 2'b00} + (i[1] ? 64'h0 : a);
        else
            tg = (vc ? s_cnt : s_lnk) & ~64'h3;
        e_adr = e_tk ? tg : a + 64'h4;
        if (!s_m64)
            e_adr[63:32] = 32'h0;
        FETCH.present(i, a);
        #1;
        chk(rv, 1'b1, "no result pulse");
        chk(nxt, e_adr, "next address");
        chk(nxt, e_adr, "target form");
        chk(tk, e_tk, "taken");
        chk(tk, e_tk, "ignored bits");
        if (!lng)
            chk(pt, e_pt, "prediction");
        chk(inv, e_inv, "invalid form");
        if (!e_inv && !lng)
            s_cnt = dn;
        if (!e_inv && i[0])
            s_lnk = s_m64 ? a + 64'h4 : {32'h0, a[31:0] + 32'h4};
        chk(lnk, s_lnk, "link");
        chk(cnt, s_cnt, "count");
        bus(1'b0, `BTC_OFF_STATUS, 32'h0, 4'hF);
        chk(r & 32'hD, {28'h0, s_m64, e_inv, 1'b0, e_tk}, "status");
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog at three times the expected run of some 3,000 cycles.
    initial
    begin
        #90000;
        n_mismatch++;
        finish_test;
    end
    // Reset, register defaults, then every options code in every form.
    initial
    begin
        repeat (8) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        bus(1'b0, `BTC_OFF_CTRL, 32'h0, 4'hF);
        chk(r, `BTC_CTRL_RESET, "ctrl reset");
        for (int a = 0; a < 5; a++)
        begin
            bus(1'b0, a[2:0], 32'h0, 4'hF);
            chk(r, 32'h0, "register reset");
        end
        bus(1'b1, 3'h7, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 3'h7, 32'h0, 4'hF);
        chk(r, 32'h0, "unmapped");
        bus(1'b1, `BTC_OFF_COND, 32'hA5A5_A5A5, 4'h1);
        bus(1'b0, `BTC_OFF_COND, 32'h0, 4'hF);
        chk(r, 32'h0000_00A5, "byte lanes");
        for (int n = 0; n < 128; n++)
        begin
            x = $random(seed);
            s_m64 = x[31];
            s_cond = $random(seed);
            s_lnk = {$random(seed), $random(seed)};
            s_cnt = {$random(seed), $random(seed)};
            if (x[30:29] == 2'h0)
                s_cnt = 64'h1;
            if (x[30:29] == 2'h1)
                s_cnt = 64'h0000_0001_0000_0001;
            bus(1'b1, `BTC_OFF_CTRL, {31'h0, s_m64}, 4'hF);
            wr64(`BTC_OFF_LINK_LO, s_lnk);
            wr64(`BTC_OFF_COUNT_LO, s_cnt);
            bus(1'b1, `BTC_OFF_COND, s_cond, 4'hF);
            c = {$random(seed), $random(seed)} & ~64'h3;
            case (n % 4)
                0: iw = {`BTC_OPC_LONG, x[25:0]};
                1: iw = {`BTC_OPC_COND, n[6:2], x[20:0]};
                2: iw = {`BTC_OPC_XL, n[6:2], x[20:16], 5'h0,
                    `BTC_XO_VIA_LINK, x[0]};
                default: iw = {`BTC_OPC_XL, n[6:2], x[20:16], 5'h0,
                    `BTC_XO_VIA_COUNT, x[0]};
            endcase
            run_branch(iw, c);
        end
        finish_test;
    end
endmodule // btc_branch_unit_tb
`default_nettype wire
